// >>> logic/nsx_regs.svh
// constants for the nibble-swap / xor / direction-load execution block
`ifndef NSX_REGS_SVH
`define NSX_REGS_SVH
`define NSX_DIR_PORT_A   5'h06
`define NSX_DIR_PORT_B   5'h07
`define NSX_DIR_RESET    8'hFF
`define NSX_ACC_RESET    8'h00
`define NSX_ZERO_RESET   1'b0
`define NSX_WADDR_RESET  5'h00
`define NSX_WDATA_RESET  8'h00
`define NSX_DEST_ACC     1'b0
`define NSX_DEST_FILE    1'b1
`endif

// >>> logic/nsx_pkg.sv
// types for the execution block
package nsx_pkg;
  typedef enum logic [1:0]
  {
    NSX_OP_SWAP,
    NSX_OP_DIR,
    NSX_OP_XORL,
    NSX_OP_XORF
  } nsx_op_t;
endpackage : nsx_pkg

// >>> logic/nsx_res_if.sv
// result path between the alu and the top
`timescale 1ns/100ps
interface nsx_res_if;
  logic [7:0] result;
  logic       to_file;
  logic       to_acc;
  logic       zero_upd;
  logic       zero_val;
  logic       dir_load;
  modport alu (output result, output to_file, output to_acc, output zero_upd, output zero_val, output dir_load);
  modport top (input result, input to_file, input to_acc, input zero_upd, input zero_val, input dir_load);
endinterface : nsx_res_if

// >>> logic/nsx_alu.sv
// combinational operation unit
`timescale 1ns/100ps
module nsx_alu
  import nsx_pkg::*;
(
  input  wire logic    op_valid,
  input  nsx_op_t      op,
  input  wire logic    dest_bit,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] operand,
  nsx_res_if.alu       res
);
  `include "nsx_regs.svh"
  wire logic [7:0] swap_val = {operand[3:0], operand[7:4]};
  wire logic [7:0] xor_val  = acc ^ operand;
  wire logic       is_xor   = op_valid && (op == NSX_OP_XORL || op == NSX_OP_XORF);
  wire logic       has_dest = op == NSX_OP_SWAP || op == NSX_OP_XORF;

  assign res.result   = (op == NSX_OP_SWAP) ? swap_val : (op == NSX_OP_DIR) ? acc : xor_val;
  assign res.to_file  = op_valid && has_dest && dest_bit == `NSX_DEST_FILE;
  assign res.to_acc   = op_valid && (op == NSX_OP_XORL || (has_dest && dest_bit == `NSX_DEST_ACC));
  assign res.zero_upd = is_xor;
  assign res.zero_val = (xor_val == 8'h00);
  assign res.dir_load = op_valid && op == NSX_OP_DIR;
endmodule : nsx_alu

// >>> logic/nsx_exec.sv
// top: operation execution with accumulator, zero flag and direction registers
`timescale 1ns/100ps
module nsx_exec
  import nsx_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       op_valid,
  input  wire logic [1:0] op_code,
  input  wire logic       dest_bit,
  input  wire logic [4:0] file_addr,
  input  wire logic [7:0] operand,
  output logic [7:0]      acc_q,
  output logic            zero_q,
  output logic [7:0]      dir_a_q,
  output logic [7:0]      dir_b_q,
  output logic            file_we,
  output logic [4:0]      file_waddr,
  output logic [7:0]      file_wdata
);
  `include "nsx_regs.svh"
  // ************************************************
  // reset release
  // ************************************************
  logic sync1_r;
  logic sync2_r;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= 1'b1;
      sync2_r <= sync1_r;
    end
  end
  wire logic rst_int_n = sync2_r;

  // ************************************************
  // execution
  // ************************************************
  nsx_res_if res ();
  wire nsx_op_t op = nsx_op_t'(op_code);
  wire logic    go = op_valid && clk_en && rst_int_n;
  nsx_alu u_alu
  (
    .op_valid (go),
    .op       (op),
    .dest_bit (dest_bit),
    .acc      (acc_q),
    .operand  (operand),
    .res      (res)
  );
  // one decode for both direction registers keeps their address match identical
  function automatic logic nsx_dir_hit
  (
    input logic       load,
    input logic [4:0] addr,
    input logic [4:0] target
  );
    return load && addr == target;
  endfunction : nsx_dir_hit

  // other direction register numbers are ignored
  wire logic dir_a_sel = nsx_dir_hit(res.dir_load, file_addr, `NSX_DIR_PORT_A);
  wire logic dir_b_sel = nsx_dir_hit(res.dir_load, file_addr, `NSX_DIR_PORT_B);

  // ************************************************
  // accumulator and zero flag
  // ************************************************
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      acc_q  <= `NSX_ACC_RESET;
      zero_q <= `NSX_ZERO_RESET;
    end
    else if (clk_en)
    begin
      if (res.to_acc)
        acc_q <= res.result;
      if (res.zero_upd)
        zero_q <= res.zero_val;
    end
  end

  // ************************************************
  // direction registers
  // ************************************************
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      dir_a_q <= `NSX_DIR_RESET;
      dir_b_q <= `NSX_DIR_RESET;
    end
    else if (clk_en)
    begin
      if (dir_a_sel)
        dir_a_q <= res.result;
      if (dir_b_sel)
        dir_b_q <= res.result;
    end
  end

  // ************************************************
  // file write port
  // ************************************************
  // strobe not frozen by clk_en: a held strobe would repeat the write
  // on every stalled cycle; address and data still freeze through go
  always_ff @(posedge core_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      file_we    <= 1'b0;
      file_waddr <= `NSX_WADDR_RESET;
      file_wdata <= `NSX_WDATA_RESET;
    end
    else
    begin
      file_we <= res.to_file;
      if (res.to_file)
      begin
        file_waddr <= file_addr;
        file_wdata <= res.result;
      end
    end
  end

  // ************************************************
  // checks
  // ************************************************
  property p_swap;
    @(posedge core_clk) disable iff (!rst_int_n)
    go && op == NSX_OP_SWAP && dest_bit |=> file_we && file_wdata == {$past(operand[3:0]), $past(operand[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("swap result wrong");
  property p_swap_acc;
    @(posedge core_clk) disable iff (!rst_int_n)
    go && op == NSX_OP_SWAP && !dest_bit |=> acc_q == {$past(operand[3:0]), $past(operand[7:4])} && !file_we;
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong");
  property p_noflag;
    @(posedge core_clk) disable iff (!rst_int_n)
    go && (op == NSX_OP_SWAP || op == NSX_OP_DIR) |=> $stable(zero_q);
  endproperty
  a_noflag: assert property (p_noflag) else $error("zero flag moved");
  property p_dir;
    @(posedge core_clk) disable iff (!rst_int_n)
    go && op == NSX_OP_DIR && file_addr == 5'h06 |=> dir_a_q == $past(acc_q) && $stable(acc_q);
  endproperty
  a_dir: assert property (p_dir) else $error("direction load wrong");
  property p_xorl;
    @(posedge core_clk) disable iff (!rst_int_n)
    go && op == NSX_OP_XORL |=> acc_q == ($past(acc_q) ^ $past(operand)) && !file_we;
  endproperty
  a_xorl: assert property (p_xorl) else $error("literal xor wrong");
  property p_xorf;
    @(posedge core_clk) disable iff (!rst_int_n)
    go && op == NSX_OP_XORF && dest_bit |=> file_we && file_wdata == ($past(acc_q) ^ $past(operand)) && $stable(acc_q);
  endproperty
  a_xorf: assert property (p_xorf) else $error("file xor wrong");
  property p_zero;
    @(posedge core_clk) disable iff (!rst_int_n)
    go && (op == NSX_OP_XORL || op == NSX_OP_XORF) |=> zero_q == ($past(acc_q) == $past(operand));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_hold;
    @(posedge core_clk) disable iff (!rst_int_n)
    !clk_en |=> $stable(acc_q) && $stable(zero_q) && $stable(dir_b_q);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while frozen");
  property p_fwe;
    @(posedge core_clk) disable iff (!rst_int_n)
    !go |=> !file_we;
  endproperty
  a_fwe: assert property (p_fwe) else $error("spurious file write");

  property p_xorf_acc;
    @(posedge core_clk) disable iff (!rst_int_n)
    go && op == NSX_OP_XORF && !dest_bit |=> acc_q == ($past(acc_q) ^ $past(operand)) && !file_we;
  endproperty
  a_xorf_acc: assert property (p_xorf_acc) else $error("file xor to acc wrong");
  property p_dir_b;
    @(posedge core_clk) disable iff (!rst_int_n)
    go && op == NSX_OP_DIR && file_addr == `NSX_DIR_PORT_B |=> dir_b_q == $past(acc_q) && $stable(dir_a_q);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("second direction load wrong");
  property p_dir_none;
    @(posedge core_clk) disable iff (!rst_int_n)
    go && op == NSX_OP_DIR && file_addr != `NSX_DIR_PORT_A && file_addr != `NSX_DIR_PORT_B
      |=> $stable(dir_a_q) && $stable(dir_b_q) && !file_we;
  endproperty
  a_dir_none: assert property (p_dir_none) else $error("unknown direction number changed state");
  property p_others_dir;
    @(posedge core_clk) disable iff (!rst_int_n)
    go && op != NSX_OP_DIR |=> $stable(dir_a_q) && $stable(dir_b_q);
  endproperty
  a_others_dir: assert property (p_others_dir) else $error("direction register moved");
  property p_idle;
    @(posedge core_clk) disable iff (!rst_int_n)
    !go |=> $stable(acc_q) && $stable(zero_q) && $stable(dir_a_q) && $stable(dir_b_q);
  endproperty
  a_idle: assert property (p_idle) else $error("state moved without an operation");
  property p_wport;
    @(posedge core_clk) disable iff (!rst_int_n)
    $changed(file_waddr) || $changed(file_wdata) |-> file_we;
  endproperty
  a_wport: assert property (p_wport) else $error("write port moved without a write");

  // ************************************************
  // coverage
  // ************************************************
  c_swap: cover property (@(posedge core_clk) go && op == NSX_OP_SWAP);
  c_dir: cover property (@(posedge core_clk) dir_b_sel);
  c_zero: cover property (@(posedge core_clk) go && op == NSX_OP_XORL ##1 zero_q);
  c_xorf: cover property (@(posedge core_clk) go && op == NSX_OP_XORF && dest_bit);
  c_freeze: cover property (@(posedge core_clk) file_we && !clk_en);
endmodule : nsx_exec

// >>> testbench/nsx_file_model.sv
// data file model feeding operands to the execution block
`timescale 1ns/100ps
module nsx_file_model
(
  input  wire logic       core_clk,
  input  wire logic       file_we,
  input  wire logic [4:0] file_waddr,
  input  wire logic [7:0] file_wdata,
  input  wire logic [4:0] rd_addr,
  output logic [7:0]      rd_data
);
  logic [7:0] mem_r [32];
  // distinct preload so a wrong address shows
  initial
    for (int i = 0; i < 32; i++)
      mem_r[i] = 8'(i) ^ 8'hA5;
  assign rd_data = mem_r[rd_addr];
  always @(posedge core_clk)
    if (file_we)
      mem_r[file_waddr] <= file_wdata;
endmodule : nsx_file_model

// >>> testbench/nibble_swap_xor_pin_direction_load_exec_tb.sv
// self-checking bench for the execution block
`timescale 1ns/100ps
module nibble_swap_xor_pin_direction_load_exec_tb;
  typedef struct {logic [1:0] op; logic d; logic [4:0] a; logic [7:0] k, acc; logic z, we; logic [7:0] wd;} nsx_row_t;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       clk_en = 1'b0;
  logic       op_valid = 1'b0;
  logic [1:0] op_code = 2'h0;
  logic       dest_bit = 1'b0;
  logic [4:0] file_addr = 5'h00;
  logic [7:0] lit = 8'h00;
  logic [7:0] operand, rd_data, acc_q, dir_a_q, dir_b_q, file_wdata;
  logic [4:0] file_waddr;
  logic       zero_q, file_we;
  int         n_fail = 0;
  int         checked = 0;
  nsx_row_t   rows [12];
  always #2.5 core_clk = ~core_clk;
  // literal only for the literal xor, else the file read
  assign operand = (op_code == 2'h2) ? lit : rd_data;
  nsx_exec nsx_exec_inst (.core_clk, .rst_n, .clk_en, .op_valid, .op_code, .dest_bit, .file_addr,
    .operand, .acc_q, .zero_q, .dir_a_q, .dir_b_q, .file_we, .file_waddr, .file_wdata);
  nsx_file_model nsx_file_model_inst (.core_clk, .file_we, .file_waddr, .file_wdata,
    .rd_addr(file_addr), .rd_data);
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic issue(input nsx_row_t r);
    op_valid = 1'b1;
    op_code = r.op;
    dest_bit = r.d;
    file_addr = r.a;
    lit = r.k;
    @(posedge core_clk);
    #1;
  endtask : issue
  initial
  begin
    rows = '{'{2, 0, 0, 8'h3C, 8'h3C, 0, 0, 0}, '{2, 0, 0, 8'h3C, 8'h00, 1, 0, 0},
      '{0, 0, 1, 0, 8'h4A, 1, 0, 0}, '{3, 0, 2, 0, 8'hED, 0, 0, 0}, '{3, 1, 3, 0, 8'hED, 0, 1, 8'h4B},
      '{1, 0, 6, 0, 8'hED, 0, 0, 8'h4B}, '{1, 0, 7, 0, 8'hED, 0, 0, 8'h4B},
      '{2, 1, 4, 8'h48, 8'hA5, 0, 0, 8'h4B}, '{3, 1, 0, 0, 8'hA5, 1, 1, 8'h00}, '{2, 0, 0, 8'h48, 8'hED, 0, 0, 8'h00},
      '{0, 1, 31, 0, 8'hED, 0, 1, 8'hAB}, '{2, 0, 0, 8'hED, 8'h00, 1, 0, 8'hAB}};
    repeat (12) @(posedge core_clk);
    #1;
    chk("dir_a", dir_a_q, 8'hFF);
    chk("zero", zero_q, 8'h00);
    rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    clk_en = 1'b1;
    foreach (rows[i])
    begin
      issue(rows[i]);
      chk("acc", acc_q, rows[i].acc);
      chk("zero", zero_q, 8'(rows[i].z));
      chk("we", file_we, 8'(rows[i].we));
      chk("wdata", file_wdata, rows[i].wd);
    end
    chk("dir_a", dir_a_q, 8'hED);
    chk("dir_b", dir_b_q, 8'hED);
    chk("waddr", file_waddr, 8'h1F);
    issue('{1, 0, 5, 0, 0, 0, 0, 0});
    chk("dir_a", dir_a_q, 8'hED);
    chk("dir_b", dir_b_q, 8'hED);
    clk_en = 1'b0;
    issue('{2, 0, 0, 8'hFF, 0, 0, 0, 0});
    chk("acc", acc_q, 8'h00);
    op_valid = 1'b0;
    clk_en = 1'b1;
    @(posedge core_clk);
    #1;
    chk("zero", zero_q, 8'h01);
    // file write with a stall right behind it: the strobe must not repeat
    issue('{3, 1, 1, 0, 0, 0, 0, 0});
    chk("we", file_we, 8'h01);
    chk("wdata", file_wdata, 8'hA4);
    chk("zero", zero_q, 8'h00);
    clk_en = 1'b0;
    @(posedge core_clk);
    #1;
    chk("we", file_we, 8'h00);
    chk("acc", acc_q, 8'h00);
    // mid-run reset; an operation held across the release lands at the third edge
    rst_n = 1'b0;
    #1;
    chk("dir_a", dir_a_q, 8'hFF);
    chk("dir_b", dir_b_q, 8'hFF);
    chk("waddr", file_waddr, 8'h00);
    @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    clk_en = 1'b1;
    op_code = 2'h2;
    lit = 8'h5A;
    repeat (2)
    begin
      @(posedge core_clk);
      #1;
      chk("acc", acc_q, 8'h00);
    end
    @(posedge core_clk);
    #1;
    chk("acc", acc_q, 8'h5A);
    chk("zero", zero_q, 8'h00);
    summarize();
  end
  initial
  begin
    #1000;
    n_fail++;
    summarize();
  end
endmodule : nibble_swap_xor_pin_direction_load_exec_tb
